// >>> hdl/interrupt_vector_trap_unit.sv
// interrupt node vectoring, event transfer routing and hardware trap handling
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_trap_unit (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // register port
   input wire ivt_pkg::reg_bus_t bus_i,
   output logic [ivt_pkg::DATA_W-1:0] rdata_o,
   // peripheral sources
   input wire logic [ivt_pkg::NODE_COUNT-1:0] node_req_i,
   input wire logic [ivt_pkg::TRAP_COUNT-1:0] trap_cond_i,
   // event transfer unit
   output logic xfer_req_o,
   output logic [2:0] xfer_ch_o,
   input wire logic xfer_done_i,
   input wire logic xfer_last_i,
   // cpu core
   output ivt_pkg::cpu_req_t cpu_req_o,
   input wire logic cpu_ack_i,
   input wire logic cpu_ret_i,
   input wire logic [3:0] ret_level_i,
   input wire logic ret_trap_act_i,
   input wire logic [1:0] ret_trap_prio_i,
   // summary interrupt
   output logic irq_o
);
   import ivt_pkg::*;

   typedef struct packed {
      state_t st;
      node_ctrl_t [NODE_COUNT-1:0] node;
      logic [7:0] vseg;
      logic [1:0] vsc;
      logic [TRAP_COUNT-1:0] tflags;
      logic [TRAP_COUNT-1:0] tpend;
      logic trap_act;
      logic [1:0] trap_prio;
      logic [3:0] level;
      logic [2:0] offer_idx;
      cpu_req_t req;
      logic xfer_req;
      logic [2:0] xfer_ch;
      logic [1:0] evt_st;
      logic [1:0] evt_en;
      logic irq;
      logic [DATA_W-1:0] rdata;
   } unit_state_t;

   unit_state_t r, nx;

   logic [NODE_COUNT-1:0] pend;
   logic [NODE_COUNT-1:0][3:0] prio;
   logic arb_hit;
   logic [2:0] arb_idx;
   logic [3:0] arb_prio;
   logic [2:0] trap_idx;
   logic trap_go;

   // ****************************************
   // helpers
   // ****************************************
   // segment in the top byte, trap number scaled by the spacing below
   function automatic logic [23:0] vec_addr(input logic [7:0] seg, input logic [1:0] vsc,
                                            input logic [7:0] tn);
      logic [15:0] ofs;
      ofs = 16'({8'h00, tn} << (VEC_SHIFT_BASE + int'(vsc)));
      return {seg, ofs};
   endfunction

   // lowest set index wins; class a traps sit at the low indices
   function automatic logic [2:0] first_set(input logic [TRAP_COUNT-1:0] v);
      logic [2:0] k;
      k = 3'h0;
      for (int i = TRAP_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            k = i[2:0];
         end
      end
      return k;
   endfunction

   // ****************************************
   // arbitration among nodes
   // ****************************************
   always_comb begin
      for (int i = 0; i < NODE_COUNT; i++) begin
         pend[i] = r.node[i].req && r.node[i].en;
         prio[i] = r.node[i].prio;
      end
   end

   node_arbiter #(
      .NODES(NODE_COUNT)
   ) u_arb (
      .pend_i(pend),
      .prio_i(prio),
      .floor_i(r.level),
      .hit_o(arb_hit),
      .idx_o(arb_idx),
      .prio_o(arb_prio)
   );

   // a pending trap goes ahead unless an equal or higher trap service runs
   assign trap_idx = first_set(r.tpend);
   assign trap_go = (r.tpend != '0) && (!r.trap_act || TRAP_PRIO[trap_idx] > r.trap_prio);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nx = r;
      nx.xfer_req = 1'b0;
      nx.rdata = '0;
      // register writes first so that hardware sets below win over clears
      if (bus_i.wr) begin
         if (bus_i.addr < REG_NODE_BASE + 8'(NODE_COUNT)) begin
            nx.node[bus_i.addr[2:0]].prio = bus_i.wdata[NC_PRIO_LSB +: 4];
            nx.node[bus_i.addr[2:0]].en = bus_i.wdata[NC_EN_BIT];
            nx.node[bus_i.addr[2:0]].req = bus_i.wdata[NC_REQ_BIT];
            nx.node[bus_i.addr[2:0]].xfer_sel = bus_i.wdata[NC_XFER_BIT];
         end
         unique case (bus_i.addr)
            REG_VSEG: nx.vseg = bus_i.wdata[7:0];
            REG_CPU_CTRL1: nx.vsc = bus_i.wdata[VSC_LSB +: 2];
            REG_TRAP_FLAGS: nx.tflags = r.tflags & ~bus_i.wdata[TRAP_COUNT-1:0];
            REG_EVT_EN: nx.evt_en = bus_i.wdata[1:0];
            REG_EVT_CLR: nx.evt_st = r.evt_st & ~bus_i.wdata[1:0];
            default: ;
         endcase
      end
      // reads answer one cycle later; unmapped words read zero
      if (bus_i.rd) begin
         if (bus_i.addr < REG_NODE_BASE + 8'(NODE_COUNT)) begin
            nx.rdata = 16'({r.node[bus_i.addr[2:0]].xfer_sel, r.node[bus_i.addr[2:0]].req,
                            r.node[bus_i.addr[2:0]].en, 2'b00, r.node[bus_i.addr[2:0]].prio});
         end
         unique case (bus_i.addr)
            REG_VSEG: nx.rdata = 16'(r.vseg);
            REG_CPU_CTRL1: nx.rdata = 16'(r.vsc);
            REG_TRAP_FLAGS: nx.rdata = 16'(r.tflags);
            REG_EVT_STAT: nx.rdata = 16'(r.evt_st);
            REG_EVT_EN: nx.rdata = 16'(r.evt_en);
            default: ;
         endcase
      end
      // service state machine
      unique case (r.st)
         ST_IDLE: begin
            if (trap_go) begin
               // no enable or level can hold a trap back
               nx.req.valid = 1'b1;
               nx.req.is_trap = 1'b1;
               nx.req.trap_num = TRAP_NUM[trap_idx];
               nx.req.vector = vec_addr(r.vseg, r.vsc, TRAP_NUM[trap_idx]);
               nx.req.level = r.level;
               nx.offer_idx = trap_idx;
               nx.st = ST_OFFER;
            end else if (arb_hit && !r.trap_act) begin
               if (r.node[arb_idx].xfer_sel) begin
                  // transfer steals a cycle; no branch and no level change
                  nx.xfer_req = 1'b1;
                  nx.xfer_ch = arb_idx;
                  nx.node[arb_idx].req = 1'b0;
               end else begin
                  nx.req.valid = 1'b1;
                  nx.req.is_trap = 1'b0;
                  nx.req.trap_num = NODE_TRAP_NUM[arb_idx];
                  nx.req.vector = vec_addr(r.vseg, r.vsc, NODE_TRAP_NUM[arb_idx]);
                  nx.req.level = arb_prio;
                  nx.offer_idx = arb_idx;
                  nx.st = ST_OFFER;
               end
            end
         end
         ST_OFFER: begin
            if (cpu_ack_i) begin
               nx.req.valid = 1'b0;
               nx.st = ST_IDLE;
               if (r.req.is_trap) begin
                  nx.trap_act = 1'b1;
                  nx.trap_prio = TRAP_PRIO[r.offer_idx];
                  nx.tpend[r.offer_idx] = 1'b0;
               end else begin
                  nx.level = r.req.level;
                  nx.node[r.offer_idx].req = 1'b0;
               end
            end else if (!r.req.is_trap && trap_go) begin
               // withdraw an unaccepted branch so the trap is not delayed
               nx.req.valid = 1'b0;
               nx.st = ST_IDLE;
            end
         end
         default: begin
            nx.req.valid = 1'b0;
            nx.st = ST_IDLE;
         end
      endcase
      // return from service restores the level the cpu hands back
      if (cpu_ret_i) begin
         nx.level = ret_level_i;
         nx.trap_act = ret_trap_act_i;
         nx.trap_prio = ret_trap_prio_i;
      end
      // hardware sets last: a set in the clearing cycle is kept
      for (int i = 0; i < NODE_COUNT; i++) begin
         if (node_req_i[i]) begin
            nx.node[i].req = 1'b1;
         end
      end
      if (xfer_done_i && xfer_last_i) begin
         nx.node[0].req = 1'b1;
         nx.evt_st[EVT_EOP] = 1'b1;
      end
      nx.tpend = nx.tpend | trap_cond_i;
      nx.tflags = nx.tflags | trap_cond_i;
      if (trap_cond_i != '0) begin
         nx.evt_st[EVT_TRAP] = 1'b1;
      end
      nx.irq = |(nx.evt_st & nx.evt_en);
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.vseg <= VSEG_RESET;
         r.vsc <= VSC_RESET;
      end else begin
         r <= nx;
      end
   end

   assign rdata_o = r.rdata;
   assign xfer_req_o = r.xfer_req;
   assign xfer_ch_o = r.xfer_ch;
   assign cpu_req_o = r.req;
   assign irq_o = r.irq;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_trap_flag_set: assert property ((trap_cond_i != '0) |=>
      ((r.tflags & $past(trap_cond_i)) == $past(trap_cond_i)))
      else $error("trap flag not set");
   chk_trap_immediate: assert property ((r.st == ST_IDLE && r.tpend != '0 && !r.trap_act) |=>
      (cpu_req_o.valid && cpu_req_o.is_trap))
      else $error("trap not offered at once");
   chk_trap_vector: assert property ($rose(cpu_req_o.valid) && cpu_req_o.is_trap |->
      cpu_req_o.trap_num == TRAP_NUM[r.offer_idx])
      else $error("trap offered with wrong number");
   chk_trap_blocks_int: assert property (r.trap_act |=> !xfer_req_o)
      else $error("transfer issued during trap service");
   chk_int_above_level: assert property ((cpu_req_o.valid && !cpu_req_o.is_trap) |->
      (cpu_req_o.level > r.level))
      else $error("branch offered at or below level");
   chk_vector_segment: assert property ($rose(cpu_req_o.valid) |->
      cpu_req_o.vector[23:16] == $past(r.vseg))
      else $error("vector segment mismatch");
   chk_default_spacing: assert property (($rose(cpu_req_o.valid) && $past(r.vsc) == VSC_RESET) |->
      cpu_req_o.vector[15:0] == {6'h00, cpu_req_o.trap_num, 2'b00})
      else $error("default spacing not four bytes");
   chk_eop_vector: assert property (($rose(cpu_req_o.valid) && !cpu_req_o.is_trap && r.offer_idx == 3'h0 &&
      $past(r.vsc) == VSC_RESET) |-> (cpu_req_o.trap_num == EOP_TRAP_NUM &&
      cpu_req_o.vector[15:0] == 16'h0130))
      else $error("transfer end node vector wrong");
   chk_eop_request: assert property ((xfer_done_i && xfer_last_i) |=> r.node[0].req)
      else $error("transfer end request lost");
   chk_xfer_route: assert property ((xfer_req_o && !$past(bus_i.wr)) |-> r.node[xfer_ch_o].xfer_sel)
      else $error("transfer issued for branch node");
   chk_node_set: assert property (node_req_i[1] |=> r.node[1].req)
      else $error("node request not latched");
   chk_irq_level: assert property (irq_o == |(r.evt_st & r.evt_en))
      else $error("interrupt output disagrees with status");

   cov_trap_taken: cover property (cpu_req_o.valid && cpu_req_o.is_trap ##1 cpu_ack_i);
   cov_int_taken: cover property (cpu_req_o.valid && !cpu_req_o.is_trap && cpu_ack_i);
   cov_xfer_issued: cover property (xfer_req_o);
   cov_withdraw: cover property (r.st == ST_OFFER && !r.req.is_trap ##1 cpu_req_o.is_trap);
endmodule
`default_nettype wire

// >>> hdl/ivt_pkg.sv
// constants, types and register map of the interrupt vector and trap unit
//
// Functional notes
// - each node is served by a cpu branch or a peripheral event transfer, per configuration
// - transfer end node uses trap number 0x4C and, at default spacing, vector offset 0x0130
// - upper vector address bits come from the programmable vector segment register
// - vector spacing set by a cpu control field; default spacing four bytes
// - hardware trap forces an immediate reaction that no mask can suppress
// - trap service branches to the vector entry of that trap; class b traps share one entry
// - each trap occurrence sets its own bit in the trap flag register
// - trap pre-empts running code unless an equal or higher trap service is active
// - ordinary and transfer requests do not pre-empt an active trap service
// - each node has a control register: request, enable, four-bit priority
// - an accepted service is interrupted only by a strictly higher priority
package ivt_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NODE_COUNT = 8;
   localparam int TRAP_COUNT = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // ****************************************
   // register indices (word addresses)
   // ****************************************
   localparam logic [7:0] REG_NODE_BASE = 8'h00;
   localparam logic [7:0] REG_VSEG = 8'h10;
   localparam logic [7:0] REG_CPU_CTRL1 = 8'h11;
   localparam logic [7:0] REG_TRAP_FLAGS = 8'h12;
   localparam logic [7:0] REG_EVT_STAT = 8'h13;
   localparam logic [7:0] REG_EVT_EN = 8'h14;
   localparam logic [7:0] REG_EVT_CLR = 8'h15;

   // ****************************************
   // node control and vector field positions, vector reset values
   // ****************************************
   localparam int NC_PRIO_LSB = 0;
   localparam int NC_EN_BIT = 6;
   localparam int NC_REQ_BIT = 7;
   localparam int NC_XFER_BIT = 8;
   localparam int VSC_LSB = 0;
   localparam int VEC_SHIFT_BASE = 2; // spacing 4 bytes at field value zero
   localparam logic [1:0] VSC_RESET = 2'h0;
   localparam logic [7:0] VSEG_RESET = 8'h00;

   // ****************************************
   // trap numbers, trap priorities and event status bits
   // ****************************************
   localparam logic [7:0] EOP_TRAP_NUM = 8'h4C;
   localparam logic [7:0] NODE_TRAP_NUM [NODE_COUNT] = '{8'h4C, 8'h10, 8'h11, 8'h12,
                                                       8'h13, 8'h14, 8'h15, 8'h16};
   // class a: nmi, stack overflow, stack underflow, software break; class b share one vector
   localparam logic [7:0] TRAP_NUM [TRAP_COUNT] = '{8'h02, 8'h04, 8'h06, 8'h08,
                                                  8'h0A, 8'h0A, 8'h0A, 8'h0A};
   localparam logic [1:0] TRAP_PRIO [TRAP_COUNT] = '{2'h3, 2'h3, 2'h3, 2'h3,
                                                   2'h2, 2'h2, 2'h2, 2'h2};
   localparam int EVT_TRAP = 0;
   localparam int EVT_EOP = 1;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic xfer_sel;
      logic req;
      logic en;
      logic [3:0] prio;
   } node_ctrl_t;

   typedef struct packed {
      logic valid;
      logic [23:0] vector;
      logic [7:0] trap_num;
      logic [3:0] level;
      logic is_trap;
   } cpu_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_bus_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_OFFER = 2'b10
   } state_t;

endpackage

// >>> hdl/node_arbiter.sv
// picks the highest priority pending node above a floor level
`timescale 1ns/1ps
`default_nettype none
module node_arbiter #(
   parameter int NODES = 8
) (
   // requests
   input wire logic [NODES-1:0] pend_i,
   input wire logic [NODES-1:0][3:0] prio_i,
   input wire logic [3:0] floor_i,
   // result
   output logic hit_o,
   output logic [$clog2(NODES)-1:0] idx_o,
   output logic [3:0] prio_o
);
   // ties go to the lowest index, so scan downward and let later hits replace
   always_comb begin
      hit_o = 1'b0;
      idx_o = '0;
      prio_o = floor_i;
      for (int i = NODES - 1; i >= 0; i--) begin
         if (pend_i[i] && prio_i[i] >= prio_o && prio_i[i] > floor_i) begin
            hit_o = 1'b1;
            idx_o = i[$clog2(NODES)-1:0];
            prio_o = prio_i[i];
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/cpu_core_model.sv
// cpu core model: accepts vectored offers and restores nesting state on return
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // offer side
   input wire ivt_pkg::cpu_req_t req_i,
   input wire logic [3:0] delay_i,
   input wire logic ret_go_i,
   output logic ack_o,
   // return side
   output logic ret_o,
   output logic [3:0] level_o,
   output logic trap_act_o,
   output logic [1:0] trap_prio_o
);
   import ivt_pkg::*;
   // ****************************************
   // acceptance and nesting stack
   // ****************************************
   logic [6:0] stk [$];
   logic [6:0] cur;
   logic [3:0] cnt;
   assign {level_o, trap_act_o, trap_prio_o} = cur;
   // one ack per offer after delay_i cycles, so a slow core keeps the offer standing
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         cnt <= 4'h0;
         cur = 7'h00;
         stk.delete();
      end else begin
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         cnt <= (req_i.valid && !ack_o) ? cnt + 4'h1 : 4'h0;
         if (req_i.valid && !ack_o && cnt >= delay_i) begin
            ack_o <= 1'b1;
            stk.push_back(cur);
            // class b traps share one number, all others are class a
            cur = req_i.is_trap ? {req_i.level, 1'b1, (req_i.trap_num == TRAP_NUM[4]) ? 2'h2 : 2'h3}
                                : {req_i.level, cur[2:0]};
         end else if (ret_go_i && stk.size() > 0) begin
            cur = stk.pop_back();
            ret_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the interrupt vector and trap unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ivt_pkg::*;
   // ****************************************
   // clock, stimulus and instances
   // ****************************************
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   reg_bus_t bus = '0;
   logic [7:0] node_req = 8'h00;
   logic [7:0] trap_cond = 8'h00;
   logic xfer_done = 1'b0;
   logic xfer_last = 1'b0;
   logic ret_go = 1'b0;
   logic [3:0] ack_delay = 4'h0;
   logic [7:0] seg_now = 8'h00;
   logic [1:0] sc_now = 2'h0;
   logic [15:0] rdata;
   logic xfer_req, ack, ret, trap_act, irq;
   logic [2:0] xfer_ch;
   logic [3:0] ret_level;
   logic [1:0] ret_prio;
   cpu_req_t offer;
   int num_errors = 0;
   int checks_done = 0;
   always #20 clock_i = ~clock_i;
   interrupt_vector_trap_unit dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
      .node_req_i(node_req), .trap_cond_i(trap_cond), .xfer_req_o(xfer_req), .xfer_ch_o(xfer_ch),
      .xfer_done_i(xfer_done), .xfer_last_i(xfer_last), .cpu_req_o(offer), .cpu_ack_i(ack), .cpu_ret_i(ret),
      .ret_level_i(ret_level), .ret_trap_act_i(trap_act), .ret_trap_prio_i(ret_prio), .irq_o(irq));
   cpu_core_model cpu_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(offer), .delay_i(ack_delay),
      .ret_go_i(ret_go), .ack_o(ack), .ret_o(ret), .level_o(ret_level), .trap_act_o(trap_act),
      .trap_prio_o(ret_prio));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_i);
      bus.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
      @(posedge clock_i);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock_i);
      bus.rd <= 1'b0;
      @(negedge clock_i);
      chk(what, 32'(exp), 32'(rdata));
   endtask
   // waits for an offer, judges it, then lets the core model accept it
   task automatic see_offer(input logic [7:0] tn, input logic trap, input logic [3:0] lvl);
      logic [15:0] off;
      off = {8'h00, tn} << (2 + sc_now);
      @(negedge clock_i);
      for (int n = 0; n < 30 && offer.valid !== 1'b1; n++) @(negedge clock_i);
      chk("offer valid", 32'h1, 32'(offer.valid));
      chk("trap number", 32'(tn), 32'(offer.trap_num));
      chk("vector", 32'({seg_now, off}), 32'(offer.vector));
      chk("trap kind", 32'(trap), 32'(offer.is_trap));
      if (!trap) begin
         chk("level", 32'(lvl), 32'(offer.level));
      end
      for (int n = 0; n < 30 && offer.valid !== 1'b0; n++) @(negedge clock_i);
   endtask
   task automatic quiet(input int n);
      repeat (n) begin
         @(negedge clock_i);
         chk("no offer", 32'h0, 32'(offer.valid));
      end
   endtask
   task automatic ret_once();
      @(posedge clock_i);
      ret_go <= 1'b1;
      @(posedge clock_i);
      ret_go <= 1'b0;
   endtask
   task automatic trap_hit(input int i);
      @(posedge clock_i);
      trap_cond[i] <= 1'b1;
      @(posedge clock_i);
      trap_cond <= 8'h00;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      rd(REG_VSEG, 16'h0000, "segment");
      rd(REG_CPU_CTRL1, 16'h0000, "spacing field");
      rd(REG_TRAP_FLAGS, 16'h0000, "trap flags");
      rd(REG_NODE_BASE, 16'h0000, "node control");
      rd(REG_EVT_CLR, 16'h0000, "clear register");
      rd(8'h20, 16'h0000, "unmapped");
   endtask
   task automatic t_nesting();
      wr(REG_NODE_BASE + 8'h01, 16'h00C5);
      see_offer(8'h10, 1'b0, 4'h5);
      rd(REG_NODE_BASE + 8'h01, 16'h0045, "request cleared");
      wr(REG_NODE_BASE + 8'h02, 16'h00C5);
      quiet(8);
      seg_now = 8'h3A;
      sc_now = 2'h1;
      wr(REG_VSEG, 16'h003A);
      wr(REG_CPU_CTRL1, 16'h0001);
      ack_delay <= 4'h6;
      wr(REG_NODE_BASE + 8'h03, 16'h00C6);
      see_offer(8'h12, 1'b0, 4'h6);
      ack_delay <= 4'h0;
      ret_once();
      quiet(6);
      ret_once();
      see_offer(8'h11, 1'b0, 4'h5);
      ret_once();
   endtask
   task automatic t_transfer();
      sc_now = 2'h0;
      wr(REG_CPU_CTRL1, 16'h0000);
      wr(REG_EVT_EN, 16'h0003);
      wr(REG_NODE_BASE, 16'h0044);
      wr(REG_NODE_BASE + 8'h04, 16'h01C3);
      for (int n = 0; n < 20 && xfer_req !== 1'b1; n++) @(negedge clock_i);
      chk("transfer pulse", 32'h1, 32'(xfer_req));
      chk("transfer channel", 32'h4, 32'(xfer_ch));
      quiet(1);
      chk("transfer pulse", 32'h0, 32'(xfer_req));
      rd(REG_NODE_BASE + 8'h04, 16'h0143, "request cleared");
      @(posedge clock_i);
      xfer_done <= 1'b1;
      xfer_last <= 1'b1;
      @(posedge clock_i);
      xfer_done <= 1'b0;
      xfer_last <= 1'b0;
      see_offer(EOP_TRAP_NUM, 1'b0, 4'h4);
      chk("summary irq", 32'h1, 32'(irq));
      rd(REG_EVT_STAT, 16'h0002, "event status");
      wr(REG_EVT_CLR, 16'h0002);
      quiet(2);
      chk("summary irq", 32'h0, 32'(irq));
      ret_once();
   endtask
   task automatic t_traps();
      wr(REG_EVT_EN, 16'h0000);
      wr(REG_NODE_BASE + 8'h05, 16'h004F);
      trap_hit(4);
      see_offer(TRAP_NUM[4], 1'b1, 4'h0);
      rd(REG_TRAP_FLAGS, 16'h0010, "trap flags");
      rd(REG_EVT_STAT, 16'h0001, "event status");
      chk("summary irq", 32'h0, 32'(irq));
      @(posedge clock_i);
      node_req[5] <= 1'b1;
      @(posedge clock_i);
      node_req <= 8'h00;
      quiet(8);
      trap_hit(0);
      see_offer(TRAP_NUM[0], 1'b1, 4'h0);
      trap_hit(5);
      quiet(8);
      ret_once();
      quiet(6);
      ret_once();
      see_offer(TRAP_NUM[5], 1'b1, 4'h0);
      ret_once();
      see_offer(NODE_TRAP_NUM[5], 1'b0, 4'hF);
      ret_once();
      rd(REG_TRAP_FLAGS, 16'h0031, "trap flags");
      wr(REG_TRAP_FLAGS, 16'h0031);
      wr(REG_EVT_CLR, 16'h0001);
      rd(REG_TRAP_FLAGS, 16'h0000, "trap flags");
      rd(REG_EVT_STAT, 16'h0000, "event status");
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // main sequence; reset held two cycles
   initial begin
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_nesting();
      t_transfer();
      t_traps();
      end_of_test();
   end
   // the run needs well under a thousand cycles
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
